// File: common/mts_pkg.sv
/*
 Package for the microprogram trap sequencer: widths, request ranks,
 forced routine-start addresses, sub-cycle timing and state codes.
 Assumes one CPU cycle is split into a fixed number of mclk phases.
*/
package mts_pkg;
	localparam int unsigned MTS_NUM_REQ = 10;
	localparam int unsigned MTS_HALF_W = 8;
	localparam int unsigned MTS_WORD_W = 8;
	// Sub-cycle phases: one phase is 45 ns-equivalent time slot of the cycle
	localparam int unsigned MTS_PHASES = 4;
	localparam logic [1:0] MTS_PH_0_45 = 2'h0;
	localparam logic [1:0] MTS_PH_90_135 = 2'h2;
	localparam logic [1:0] MTS_PH_LAST = 2'h3;
	localparam logic [1:0] MTS_PH_RESET = 2'h0;
	// Request index 0 ranks highest; index 0 is the selector data transfer
	localparam int unsigned MTS_SEL_XFER = 0;
	localparam logic [3:0] MTS_ADDR_CHECK_REQ = 4'h8;
	localparam logic [15:0] MTS_TRAP_BASE = 16'hd000;
	localparam logic [15:0] MTS_TRAP_STEP = 16'h0040;
	localparam logic [15:0] MTS_ADDR_RESET = 16'h0000;
	typedef enum logic [2:0] {
		MTS_IDLE = 3'b000,
		MTS_TRAP1 = 3'b001,
		MTS_TRAP2 = 3'b010,
		MTS_TRAP3 = 3'b011,
		MTS_TRAP4 = 3'b100
	} mts_state_t;
endpackage

// File: core/mts_rank_picker.sv
/*
 Fixed-rank arbiter for the trap sequencer: picks the lowest-numbered
 active request. Assumes requests are synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module mts_rank_picker #(
	parameter int unsigned N = 10
) (
	input wire logic [N-1:0] req,
	output logic any,
	output logic [3:0] idx
);
	always_comb begin
		any = 1'b0;
		idx = 4'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = 4'(i);
			end
		end
	end
endmodule
`default_nettype wire

// File: core/mts_trap_sequencer.sv
/*
 Trap sequencer: forces a branch out of the running microprogram,
 saves the link through a branch-and-link word and restores it on a
 return word. Trap-1..3 cycles each set an interlock latch at the
 90-135 phase. Assumes request sources and microprogram decode logic
 sit on mclk; word-type decode comes from the control word register.
 A higher rank overtakes the routine in service only at a trap-1 start,
 never inside a running trap-1..4 sequence.
*/
// Notes on behaviour
// - Simultaneous requests served highest rank first
// - Higher request preempts; lower stays pending
// - Selector transfers top rank, bypass trapping
// - Trap-1 loads forced address, next into buffer
// - Forced address chosen by served operation
// - First trapped word fetched into control register
// - Trap-2 link-saves flag, aux, next halves
// - Return word restores flag, aux, address halves
// - Trap-1 needs no inhibit, request, 0-time, no storage-1
// - Trap-1 blocks traps; sets interlock at 90-135
// - Trap-1 forces address into both halves
// - Block latch set trap-1, cleared trap-4
// - Trap-3/4 stop endless trap-1/2 looping
// - Address check discontinues using routine
`timescale 1ns/1ps
`default_nettype none
module mts_trap_sequencer
	import mts_pkg::*;
#(
	parameter int unsigned HW = mts_pkg::MTS_HALF_W,
	parameter int unsigned WW = mts_pkg::MTS_WORD_W
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [mts_pkg::MTS_NUM_REQ-1:0] req,
	input wire logic inhibit_traps,
	input wire logic stg1_cycle,
	input wire logic addr_invalid,
	input wire logic [HW-1:0] gen_high_half,
	input wire logic [HW-1:0] gen_low_half,
	input wire logic [31:0] cs_word,
	input wire logic is_bal_word,
	input wire logic is_return_word,
	input wire logic routine_done,
	input wire logic [WW-1:0] flag_word,
	input wire logic [WW-1:0] aux_word,
	input wire logic [2*WW+2*HW-1:0] link_rd_data,
	output logic [1:0] phase,
	output logic sel_xfer_grant,
	output logic [3:0] serving,
	output logic serving_valid,
	output logic [HW-1:0] addr_high_half,
	output logic [HW-1:0] addr_low_half,
	output logic [HW-1:0] next_high_half,
	output logic [HW-1:0] next_low_half,
	output logic [31:0] ctrl_word,
	output logic link_wr,
	output logic [2*WW+2*HW-1:0] link_wr_data,
	output logic restore_valid,
	output logic [WW-1:0] flag_restore,
	output logic [WW-1:0] aux_restore,
	output logic routine_abort,
	output logic trap_block_latch,
	output logic [2:0] cycle_interlock,
	output logic trap1_active
);
	import mts_pkg::*;

	// ------------------------------------------------------------
	// Sub-cycle phase and state
	// ------------------------------------------------------------
	logic [1:0] phase_q, phase_d;
	mts_state_t state_q, state_d;
	logic [MTS_NUM_REQ-1:0] pend_q, pend_d;
	logic [3:0] serve_q, serve_d;
	logic serve_v_q, serve_v_d;
	logic blk_q, blk_d;
	logic [2:0] ilk_q, ilk_d;
	logic [HW-1:0] mh_q, mh_d, ml_q, ml_d, nh_q, nh_d, nl_q, nl_d;
	logic [31:0] cw_q;
	logic lw_q;
	logic [2*WW+2*HW-1:0] lwd_q;
	logic rv_q;
	logic [WW-1:0] fr_q, ar_q;
	logic ab_q;

	wire cyc_end = (phase_q == MTS_PH_LAST);
	wire at_0time = (phase_q == MTS_PH_0_45);
	wire at_90 = (phase_q == MTS_PH_90_135);
	assign phase_d = cyc_end ? MTS_PH_RESET : phase_q + 2'h1;

	// ------------------------------------------------------------
	// Request arbitration
	// ------------------------------------------------------------
	// Address check raises its own request line; latched with the rest
	wire [MTS_NUM_REQ-1:0] req_all = req | (MTS_NUM_REQ'(addr_invalid) << MTS_ADDR_CHECK_REQ);
	wire [MTS_NUM_REQ-1:0] pend_now = pend_q | req_all;
	// Selector transfers never enter the trap path
	wire [MTS_NUM_REQ-1:0] trap_req = pend_now & ~(MTS_NUM_REQ'(1) << MTS_SEL_XFER);
	logic win_any;
	logic [3:0] win_idx;

	mts_rank_picker #(.N(MTS_NUM_REQ)) u_pick (
		.req(trap_req),
		.any(win_any),
		.idx(win_idx)
	);

	// Preemption: a running routine is overtaken by a better rank
	wire preempt = serve_v_q && win_any && (win_idx < serve_q);
	wire trap_start = (state_q == MTS_IDLE) && !blk_q && !inhibit_traps && win_any && at_0time
		&& !stg1_cycle && (!serve_v_q || preempt);

	// Forced start address is a pure function of the served rank
	function automatic logic [15:0] trap_addr(input logic [3:0] idx);
		trap_addr = MTS_TRAP_BASE + (16'(idx) * MTS_TRAP_STEP);
	endfunction
	wire [15:0] forced = trap_addr(win_idx);

	// ------------------------------------------------------------
	// Trap cycle sequencing
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		ilk_d = ilk_q;
		blk_d = blk_q;
		serve_d = serve_q;
		serve_v_d = serve_v_q;
		pend_d = pend_now & ~(MTS_NUM_REQ'(1) << MTS_SEL_XFER);
		unique case (state_q)
			MTS_IDLE: begin
				if (trap_start) begin
					state_d = MTS_TRAP1;
					blk_d = 1'b1;
					serve_d = win_idx;
					serve_v_d = 1'b1;
					pend_d[win_idx] = 1'b0;
				end else if (routine_done || is_return_word) begin
					serve_v_d = 1'b0;
				end
			end
			MTS_TRAP1: begin
				// Source drops its line a cycle late; keep it from re-latching
				pend_d[serve_q] = 1'b0;
				if (at_90) ilk_d[0] = 1'b1;
				if (cyc_end) state_d = MTS_TRAP2;
			end
			MTS_TRAP2: begin
				if (at_90) ilk_d[1] = 1'b1;
				if (cyc_end) state_d = MTS_TRAP3;
			end
			MTS_TRAP3: begin
				if (at_90) ilk_d[2] = 1'b1;
				if (cyc_end) state_d = MTS_TRAP4;
			end
			MTS_TRAP4: begin
				if (cyc_end) begin
					state_d = MTS_IDLE;
					blk_d = 1'b0;
					ilk_d = 3'h0;
				end
			end
			default: state_d = MTS_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// Address registers
	// ------------------------------------------------------------
	// The trap address goes in at 0-45 time as trap-1 starts; normal load suppressed
	wire load_forced = trap_start;
	wire load_normal = cyc_end && (state_q == MTS_IDLE || state_q == MTS_TRAP3) && !rv_q;
	always_comb begin
		mh_d = mh_q;
		ml_d = ml_q;
		nh_d = nh_q;
		nl_d = nl_q;
		if (load_forced) begin
			mh_d = forced[2*HW-1:HW];
			ml_d = forced[HW-1:0];
			nh_d = gen_high_half;
			nl_d = gen_low_half;
		end else if (rv_q) begin
			mh_d = link_rd_data[2*HW-1:HW];
			ml_d = link_rd_data[HW-1:0];
		end else if (load_normal) begin
			mh_d = gen_high_half;
			ml_d = gen_low_half;
			nh_d = gen_high_half;
			nl_d = gen_low_half;
		end
	end

	// Link save in trap-2 at 0-45 once trap-1 interlock is set
	wire do_link = (state_q == MTS_TRAP2) && ilk_q[0] && at_0time && is_bal_word;
	wire do_ret = is_return_word && at_0time && (state_q == MTS_IDLE);

	always_ff @(posedge mclk) begin
		if (rst) begin
			phase_q <= MTS_PH_RESET;
			state_q <= MTS_IDLE;
			blk_q <= 1'b0;
			ilk_q <= 3'h0;
		end else begin
			phase_q <= phase_d;
			state_q <= state_d;
			blk_q <= blk_d;
			ilk_q <= ilk_d;
		end
	end

	// Pending latch and the rank now in service
	always_ff @(posedge mclk) begin
		if (rst) begin
			pend_q <= '0;
			serve_q <= 4'h0;
			serve_v_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
			serve_q <= serve_d;
			serve_v_q <= serve_v_d;
		end
	end

	// Address halves and next-address buffer
	always_ff @(posedge mclk) begin
		if (rst) begin
			mh_q <= '0;
			ml_q <= '0;
			nh_q <= '0;
			nl_q <= '0;
		end else begin
			mh_q <= mh_d;
			ml_q <= ml_d;
			nh_q <= nh_d;
			nl_q <= nl_d;
		end
	end

	// ------------------------------------------------------------
	// Control word, link save/restore, abort
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst)
			cw_q <= 32'h0;
		else if (at_0time)
			cw_q <= cs_word;
	end

	// Link save: data held until the next trap-2 branch-and-link word
	always_ff @(posedge mclk) begin
		if (rst) begin
			lw_q <= 1'b0;
			lwd_q <= '0;
		end else begin
			lw_q <= do_link;
			if (do_link) lwd_q <= {flag_word, aux_word, nh_q, nl_q};
		end
	end

	// Flag and aux words reloaded on a return word
	always_ff @(posedge mclk) begin
		if (rst) begin
			rv_q <= 1'b0;
			fr_q <= '0;
			ar_q <= '0;
		end else begin
			rv_q <= do_ret;
			if (do_ret) begin
				fr_q <= link_rd_data[2*WW+2*HW-1:WW+2*HW];
				ar_q <= link_rd_data[WW+2*HW-1:2*HW];
			end
		end
	end

	// Address check: the offending routine is not resumed, so no return follows
	always_ff @(posedge mclk) begin
		if (rst)
			ab_q <= 1'b0;
		else
			ab_q <= trap_start && (win_idx == MTS_ADDR_CHECK_REQ);
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign phase = phase_q;
	assign sel_xfer_grant = pend_now[MTS_SEL_XFER] && at_0time;
	assign serving = serve_q;
	assign serving_valid = serve_v_q;
	assign addr_high_half = mh_q;
	assign addr_low_half = ml_q;
	assign next_high_half = nh_q;
	assign next_low_half = nl_q;
	assign ctrl_word = cw_q;
	assign link_wr = lw_q;
	assign link_wr_data = lwd_q;
	assign restore_valid = rv_q;
	assign flag_restore = fr_q;
	assign aux_restore = ar_q;
	assign routine_abort = ab_q;
	assign trap_block_latch = blk_q;
	assign cycle_interlock = ilk_q;
	assign trap1_active = (state_q == MTS_TRAP1);
endmodule
`default_nettype wire

// File: dv/mts_req_src.sv
/*
 Request source model: holds each raised request line until it is served.
 Assumes serving is valid while trap1_active is high.
*/
`timescale 1ns/1ps
`default_nettype none
module mts_req_src
	import mts_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [mts_pkg::MTS_NUM_REQ-1:0] raise,
	input wire logic trap1_active,
	input wire logic sel_xfer_grant,
	input wire logic [3:0] serving,
	output logic [mts_pkg::MTS_NUM_REQ-1:0] req
);
	wire logic [9:0] served = trap1_active ? 10'h1 << serving : 10'h0;
	always_ff @(posedge mclk) begin
		if (rst)
			req <= 10'h0;
		else
			req <= (req | raise) & ~served & ~{9'h0, sel_xfer_grant};
	end
endmodule
`default_nettype wire

// File: dv/mts_trap_sequencer_chk.sv
/*
 Port checker for the trap sequencer.
 Assumes one mclk domain; bound by the statement at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module mts_trap_sequencer_chk
	import mts_pkg::*;
#(
	parameter int unsigned HW = 8,
	parameter int unsigned WW = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic inhibit_traps,
	input wire logic stg1_cycle,
	input wire logic [WW-1:0] flag_word,
	input wire logic [WW-1:0] aux_word,
	input wire logic [HW-1:0] gen_high_half,
	input wire logic [HW-1:0] gen_low_half,
	input wire logic [2*WW+2*HW-1:0] link_rd_data,
	input wire logic [1:0] phase,
	input wire logic sel_xfer_grant,
	input wire logic [3:0] serving,
	input wire logic [HW-1:0] addr_high_half,
	input wire logic [HW-1:0] addr_low_half,
	input wire logic [HW-1:0] next_high_half,
	input wire logic [HW-1:0] next_low_half,
	input wire logic link_wr,
	input wire logic [2*WW+2*HW-1:0] link_wr_data,
	input wire logic restore_valid,
	input wire logic routine_abort,
	input wire logic trap_block_latch,
	input wire logic [2:0] cycle_interlock,
	input wire logic trap1_active
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_blk8;
		trap_block_latch [*8];
	endsequence
	sequence s_blk7;
		trap_block_latch [*7];
	endsequence
	sequence s_quiet8;
		(!$rose(trap1_active)) [*8];
	endsequence
	AST_T1_COND: assert property ($rose(trap1_active) |->
		$past(phase) == 2'h0 && !$past(inhibit_traps) && !$past(stg1_cycle))
		else $error("trap-1 began off phase 0, inhibited or in a storage-1 cycle");
	AST_T1_ADDR: assert property ($rose(trap1_active) |-> {addr_high_half, addr_low_half} == MTS_TRAP_BASE + 16'(serving) * MTS_TRAP_STEP)
		else $error("forced address does not match served rank");
	AST_T1_NEXT: assert property ($rose(trap1_active) |-> {next_high_half, next_low_half} == $past({gen_high_half, gen_low_half}))
		else $error("next halves not loaded with generated address");
	AST_CYCLE_INTERLOCK: assert property (trap1_active && phase == MTS_PH_90_135 |=> cycle_interlock[0])
		else $error("first interlock not set in trap-1");
	AST_NO_RETRAP: assert property ($rose(trap1_active) |=> s_quiet8 ##1 (!$rose(trap1_active)) [*7])
		else $error("new trap-1 within a trap sequence");
	AST_BLK_LEN: assert property ($rose(trap_block_latch) |-> s_blk8 ##1 s_blk7 ##1 !trap_block_latch)
		else $error("block latch not held for exactly fifteen cycles");
	AST_SEL: assert property (sel_xfer_grant |-> phase == MTS_PH_0_45 && !trap1_active)
		else $error("selector grant outside phase 0 or with a trap");
	AST_ABORT: assert property (routine_abort |-> serving == MTS_ADDR_CHECK_REQ)
		else $error("abort without address-check service");
	AST_LINK: assert property (link_wr |->
		link_wr_data == {$past(flag_word), $past(aux_word), next_high_half, next_low_half})
		else $error("link word does not hold flag, aux and next halves");
	AST_RET: assert property (restore_valid |=> {addr_high_half, addr_low_half} == link_rd_data[15:0])
		else $error("return did not restore address halves");
endmodule
bind mts_trap_sequencer mts_trap_sequencer_chk #(.HW(HW), .WW(WW)) mts_trap_sequencer_chk_i (.*);
`default_nettype wire

// File: dv/microprogram_trap_sequencer_test.sv
/*
 Self-checking bench for the trap sequencer.
 Assumes the request model and the bound checker compile alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module microprogram_trap_sequencer_test;
	import mts_pkg::*;
	typedef struct packed {logic [9:0] raise; logic [3:0] rank; logic fin;} mts_row_t;
	mts_row_t rows [6] = '{'{10'h30c, 4'h2, 1'b1}, '{10'h0, 4'h3, 1'b1}, '{10'h0, 4'h8, 1'b0},
		'{10'h010, 4'h4, 1'b1}, '{10'h0, 4'h9, 1'b1}, '{10'h002, 4'h1, 1'b1}};
	logic mclk = 0, rst = 1, inhibit_traps = 0, stg1_cycle = 0, addr_invalid = 0, is_return_word = 0;
	logic routine_done = 0, is_bal_word = 1, ab_seen = 0, lk_seen = 0;
	logic [7:0] gen_high_half = 8'h00, gen_low_half = 8'h3c, flag_word = 8'h96, aux_word = 8'h69;
	logic [31:0] cs_word = 32'h0, link_rd_data = 32'ha5c31234, ctrl_word, link_wr_data;
	logic [9:0] raise = 10'h0, req;
	logic [1:0] phase;
	logic [3:0] serving;
	logic [2:0] cycle_interlock;
	logic sel_xfer_grant, serving_valid, link_wr, restore_valid, routine_abort, trap_block_latch, trap1_active;
	logic [7:0] addr_high_half, addr_low_half, next_high_half, next_low_half, flag_restore, aux_restore;
	int n_errors = 0, checks = 0, k;
	mts_trap_sequencer mts_trap_sequencer_i (.*);
	mts_req_src mts_req_src_i (.*);
	initial forever #4 mclk = ~mclk;
	always @(posedge mclk) begin
		if (routine_abort)
			ab_seen <= 1'b1;
		if (link_wr)
			lk_seen <= 1'b1;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task conclude;
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task wait_trap;
		for (k = 0; k < 60 && !trap1_active; k++)
			@(negedge mclk);
	endtask
	// Ends the routine only on request, so a lower request must keep waiting
	task finish_trap(input logic fin);
		for (k = 0; k < 30 && trap_block_latch; k++)
			@(negedge mclk);
		chk(trap_block_latch, 0);
		@(posedge mclk);
		routine_done <= fin;
		@(posedge mclk);
		routine_done <= 1'b0;
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk({trap_block_latch, serving_valid, cycle_interlock, trap1_active}, 0);
		foreach (rows[i]) begin
			@(posedge mclk);
			raise <= rows[i].raise;
			gen_high_half <= 8'h40 + 8'(i);
			cs_word <= 32'hc0de0000 + 32'(i);
			@(posedge mclk);
			raise <= 10'h0;
			wait_trap;
			chk(serving, rows[i].rank);
			chk({addr_high_half, addr_low_half}, MTS_TRAP_BASE + 16'(rows[i].rank) * MTS_TRAP_STEP);
			chk({next_high_half, next_low_half}, {gen_high_half, gen_low_half});
			chk(ctrl_word, cs_word);
			finish_trap(rows[i].fin);
		end
		@(posedge mclk);
		raise <= 10'h001;
		@(posedge mclk);
		raise <= 10'h0;
		for (k = 0; k < 8 && !sel_xfer_grant; k++)
			@(negedge mclk);
		chk({sel_xfer_grant, trap1_active}, 2'b10);
		@(posedge mclk);
		inhibit_traps <= 1'b1;
		raise <= 10'h002;
		@(posedge mclk);
		raise <= 10'h0;
		repeat (8) @(negedge mclk);
		chk(trap_block_latch, 0);
		@(posedge mclk);
		inhibit_traps <= 1'b0;
		stg1_cycle <= 1'b1;
		repeat (8) @(negedge mclk);
		chk({trap1_active, trap_block_latch}, 2'b00);
		@(posedge mclk);
		stg1_cycle <= 1'b0;
		wait_trap;
		chk(serving, 1);
		finish_trap(1'b1);
		@(posedge mclk);
		addr_invalid <= 1'b1;
		@(posedge mclk);
		addr_invalid <= 1'b0;
		wait_trap;
		chk(serving, MTS_ADDR_CHECK_REQ);
		finish_trap(1'b1);
		chk({ab_seen, lk_seen}, 2'b11);
		@(posedge mclk iff phase == MTS_PH_LAST);
		is_return_word <= 1'b1;
		@(posedge mclk);
		is_return_word <= 1'b0;
		for (k = 0; k < 8 && !restore_valid; k++)
			@(negedge mclk);
		chk({restore_valid, flag_restore, aux_restore}, {1'b1, link_rd_data[31:16]});
		@(negedge mclk);
		chk({addr_high_half, addr_low_half}, link_rd_data[15:0]);
		repeat (2) @(negedge mclk);
		chk({addr_high_half, addr_low_half, next_high_half, next_low_half}, {2{gen_high_half, gen_low_half}});
		conclude;
	end
	initial begin
		#(8 * 3000);
		n_errors++;
		conclude;
	end
endmodule
`default_nettype wire
